/* File: src/ssfs_pkg.sv */
// Shared constants, encodings and state type for the serial frame sequencer.
// Assumes the system logic and the link logic both import it whole.
//
// Contract
// - CPOL0 and half-duplex idle: clock low, select high.
// - Idle clock pad enabled as master, off as slave.
// - Start: select low, transmit pad enabled.
// - Mode 0,0: data half period, then rising.
// - Select rises one period after last capture.
// - Phase zero: select pulses high between words.
// - Mode 0,1: first bit with first rising edge.
// - Phase one: select stays low across burst.
// - CPOL1 idle: clock high, select high, data low.
// - Mode 1,0: data half period, then falling.
// - Mode 1,1: first bit with first falling edge.
// - Half-duplex: 8-bit control, wait, 4-16 response.
// - Control write starts frame, MSB out immediately.
// - Half-duplex response latched on rising edges.
// - Single half-duplex: select rises, value pushed.
// - Continuous half-duplex: next control follows at once.
// - Word length 4 to 16, MSB first.
package ssfs_pkg;
    localparam int DATA_W = 16;
    localparam int CFG_W = 11;
    localparam logic [1:0] FMT_SPI = 2'h0;
    localparam logic [1:0] FMT_HALF = 2'h2;
    localparam logic [3:0] CTRL_LAST = 4'h7;
    localparam logic [3:0] SIZE_TOP = 4'hF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic RESET_SELECT = 1'b1;

    typedef enum logic [2:0] {
        SSFS_IDLE = 3'b000,
        SSFS_LEAD = 3'b001,
        SSFS_BITS = 3'b010,
        SSFS_TAIL = 3'b011,
        SSFS_WAIT = 3'b100,
        SSFS_RESP = 3'b101
    } ssfs_state_t;
endpackage : ssfs_pkg

/* File: src/ssfs_sync.sv */
// Two flip-flop synchroniser for levels and toggles entering a clock domain.
// Assumes each bit is a level or toggle that is stable for several destination edges.
`timescale 1ns/100ps
module ssfs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage, to let metastability settle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : ssfs_sync

/* File: src/ssfs_sequencer.sv */
// Frame sequencer: a one-word transmit holding stage on clk_sys, the pin engine on linkClk.
// Assumes linkClk runs at twice the serial bit rate; each linkClk cycle is half a bit.
// Configuration ports must be changed only while portEnable is low.
`timescale 1ns/100ps
module ssfs_sequencer
    import ssfs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic portEnable,
    input wire logic masterMode,
    input wire logic clockPolarityBit,
    input wire logic clockPhaseBit,
    input wire logic [1:0] frameFormat,
    input wire logic [3:0] dataSizeCode,
    input wire logic txValid,
    output logic txReady,
    input wire logic [DATA_W-1:0] txData,
    output logic rxValid,
    output logic [DATA_W-1:0] rxData,
    output logic busy,
    output logic serialClockOut,
    output logic serialClockOe,
    output logic frameSelectOut,
    output logic frameSelectOe,
    output logic serialOut,
    output logic serialOutOe,
    input wire logic serialIn
);
    // System side state.
    logic txFull, next_txFull, reqTog, next_reqTog;
    logic [DATA_W-1:0] txHold, next_txHold, next_rxData;
    logic ackSeen, next_ackSeen, rxSeen, next_rxSeen, next_rxValid;
    logic ackSync, rxSync, busySync;
    // Link side state.
    ssfs_state_t state, next_state;
    logic half, next_half, fs, next_fs, sclk, next_sclk, out, next_out;
    logic outOe, next_outOe, rxTog, next_rxTog, reqSeen, next_reqSeen;
    logic ackTog, next_ackTog, busyLink, next_busyLink, doLoad;
    logic [3:0] bitCnt, next_bitCnt;
    logic [DATA_W-1:0] txShift, next_txShift, rxShift, next_rxShift;
    logic [DATA_W-1:0] rxHold, next_rxHold, loadWord;
    logic [CFG_W-1:0] cfgSync;
    logic cfgEnable, cfgMaster, cpol, cpha, reqSync, isHalf, avail;
    logic idleClk, firstLevel, secondLevel;
    logic [1:0] cfgFormat;
    logic [3:0] cfgSize, lastIdx, alignAmt;

    // Configuration and the request toggle enter the link domain together.
    ssfs_sync #(.WIDTH(CFG_W)) u_link_sync (
        .clk(linkClk),
        .reset_n(reset_n),
        .d({portEnable, masterMode, clockPolarityBit, clockPhaseBit, frameFormat,
            dataSizeCode, reqTog}),
        .q(cfgSync)
    );

    // Acknowledge, receive toggle and busy level enter the system domain.
    ssfs_sync #(.WIDTH(3)) u_sys_sync (
        .clk(clk_sys),
        .reset_n(reset_n),
        .d({ackTog, rxTog, busyLink}),
        .q({ackSync, rxSync, busySync})
    );

    assign {cfgEnable, cfgMaster, cpol, cpha, cfgFormat, cfgSize, reqSync} = cfgSync;
    assign txReady = !txFull;
    assign busy = busySync;

    // Holding stage: a word taken here stays stable until the link acknowledges its load.
    always_comb begin
        next_txFull = txFull;
        next_txHold = txHold;
        next_reqTog = reqTog;
        next_ackSeen = ackSync;
        next_rxSeen = rxSync;
        next_rxValid = 1'b0;
        next_rxData = rxData;
        if (ackSync != ackSeen) begin
            next_txFull = 1'b0;
        end
        if (txValid && !txFull) begin
            next_txFull = 1'b1;
            next_txHold = txData;
            next_reqTog = ~reqTog;
        end
        // The link holds rxHold for a whole word, so it is settled when the toggle lands.
        if (rxSync != rxSeen) begin
            next_rxValid = 1'b1;
            next_rxData = rxHold;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            txFull <= 1'b0;
            txHold <= WORD_ZERO;
            reqTog <= 1'b0;
            ackSeen <= 1'b0;
            rxSeen <= 1'b0;
            rxValid <= 1'b0;
            rxData <= WORD_ZERO;
        end else begin
            txFull <= next_txFull;
            txHold <= next_txHold;
            reqTog <= next_reqTog;
            ackSeen <= next_ackSeen;
            rxSeen <= next_rxSeen;
            rxValid <= next_rxValid;
            rxData <= next_rxData;
        end
    end

    // Mode decode; the half-duplex format always idles low and latches on rising edges.
    assign isHalf = (cfgFormat == FMT_HALF);
    assign avail = (reqSync != reqSeen);
    assign idleClk = isHalf ? 1'b0 : cpol;
    assign firstLevel = isHalf ? 1'b0 : (cpha ? ~cpol : cpol);
    assign secondLevel = isHalf ? 1'b1 : (cpha ? cpol : ~cpol);
    assign lastIdx = isHalf ? CTRL_LAST : cfgSize;
    assign alignAmt = SIZE_TOP - cfgSize;
    // The word is left aligned so bit 15 is always the next bit out.
    assign loadWord = isHalf ? {txHold[7:0], 8'h00} : (txHold << alignAmt);

    // Pin engine: one pass per half bit period.
    always_comb begin
        next_state = state;
        next_half = half;
        next_bitCnt = bitCnt;
        next_txShift = txShift;
        next_rxShift = rxShift;
        next_fs = fs;
        next_sclk = sclk;
        next_out = out;
        next_outOe = outOe;
        next_rxHold = rxHold;
        next_rxTog = rxTog;
        next_reqSeen = reqSeen;
        next_ackTog = ackTog;
        doLoad = 1'b0;
        unique case (state)
            SSFS_IDLE: begin
                next_fs = 1'b1;
                next_sclk = idleClk;
                next_out = 1'b0;
                next_outOe = 1'b0;
                if (cfgEnable && cfgMaster && avail) begin
                    doLoad = 1'b1;
                    next_fs = 1'b0;
                    next_outOe = 1'b1;
                    next_bitCnt = 4'h0;
                    next_half = 1'b0;
                    if (isHalf) begin
                        next_state = SSFS_BITS;
                        next_out = loadWord[15];
                    end else begin
                        next_state = SSFS_LEAD;
                    end
                end
            end
            SSFS_LEAD: begin
                // Data appears half a period after select falls.
                next_state = SSFS_BITS;
                next_half = 1'b0;
                next_out = txShift[15];
                next_sclk = firstLevel;
            end
            SSFS_BITS: begin
                if (!half) begin
                    next_half = 1'b1;
                    next_sclk = secondLevel;
                    if (!isHalf) begin
                        next_rxShift = {rxShift[14:0], serialIn};
                    end
                end else if (bitCnt != lastIdx) begin
                    next_half = 1'b0;
                    next_bitCnt = bitCnt + 4'h1;
                    next_txShift = {txShift[14:0], 1'b0};
                    next_out = txShift[14];
                    next_sclk = firstLevel;
                end else if (isHalf) begin
                    // The receive direction stays quiet for the one-clock wait.
                    next_state = SSFS_WAIT;
                    next_half = 1'b0;
                    next_sclk = 1'b0;
                    next_out = 1'b0;
                end else if (cpha && avail && cfgEnable) begin
                    doLoad = 1'b1;
                    next_rxHold = rxShift;
                    next_rxTog = ~rxTog;
                    next_bitCnt = 4'h0;
                    next_half = 1'b0;
                    next_out = loadWord[15];
                    next_sclk = firstLevel;
                end else begin
                    // Phase zero always ends here, so select pulses high between words.
                    next_state = SSFS_TAIL;
                    next_sclk = idleClk;
                end
            end
            SSFS_TAIL: begin
                next_state = SSFS_IDLE;
                next_fs = 1'b1;
                next_outOe = 1'b0;
                next_out = 1'b0;
                next_sclk = idleClk;
                next_rxHold = rxShift;
                next_rxTog = ~rxTog;
            end
            SSFS_WAIT: begin
                if (!half) begin
                    next_half = 1'b1;
                    next_sclk = 1'b1;
                end else begin
                    next_state = SSFS_RESP;
                    next_half = 1'b0;
                    next_sclk = 1'b0;
                    next_bitCnt = 4'h0;
                end
            end
            SSFS_RESP: begin
                if (!half) begin
                    next_half = 1'b1;
                    next_sclk = 1'b1;
                    next_rxShift = {rxShift[14:0], serialIn};
                end else if (bitCnt != cfgSize) begin
                    next_half = 1'b0;
                    next_bitCnt = bitCnt + 4'h1;
                    next_sclk = 1'b0;
                end else if (avail && cfgEnable) begin
                    // Back to back: value leaves on this falling edge, control follows.
                    doLoad = 1'b1;
                    next_rxHold = rxShift;
                    next_rxTog = ~rxTog;
                    next_state = SSFS_BITS;
                    next_bitCnt = 4'h0;
                    next_half = 1'b0;
                    next_out = loadWord[15];
                    next_sclk = 1'b0;
                end else begin
                    next_state = SSFS_TAIL;
                    next_sclk = 1'b0;
                end
            end
            default: begin
                next_state = SSFS_IDLE;
            end
        endcase
        // Loading takes the held word and acknowledges it back to the system side.
        if (doLoad) begin
            next_txShift = loadWord;
            next_rxShift = WORD_ZERO;
            next_reqSeen = reqSync;
            next_ackTog = ~ackTog;
        end
    end

    assign next_busyLink = (next_state != SSFS_IDLE);

    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SSFS_IDLE;
            half <= 1'b0;
            bitCnt <= 4'h0;
            txShift <= WORD_ZERO;
            rxShift <= WORD_ZERO;
            fs <= RESET_SELECT;
            sclk <= 1'b0;
            out <= 1'b0;
            outOe <= 1'b0;
            rxHold <= WORD_ZERO;
            rxTog <= 1'b0;
            reqSeen <= 1'b0;
            ackTog <= 1'b0;
            busyLink <= 1'b0;
        end else begin
            state <= next_state;
            half <= next_half;
            bitCnt <= next_bitCnt;
            txShift <= next_txShift;
            rxShift <= next_rxShift;
            fs <= next_fs;
            sclk <= next_sclk;
            out <= next_out;
            outOe <= next_outOe;
            rxHold <= next_rxHold;
            rxTog <= next_rxTog;
            reqSeen <= next_reqSeen;
            ackTog <= next_ackTog;
            busyLink <= next_busyLink;
        end
    end

    // Pins; as slave the clock and select pads stay off.
    assign serialClockOut = sclk;
    assign serialClockOe = cfgMaster;
    assign frameSelectOut = fs;
    assign frameSelectOe = cfgMaster;
    assign serialOut = out;
    assign serialOutOe = outOe;

    // Checks on the pin engine.
    a_idle_low: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_IDLE && $past(state) == SSFS_IDLE && $stable(idleClk)
         && (!cpol || isHalf)) |-> (!sclk && fs && !out))
        else $error("Idle pins wrong with low clock polarity.");
    a_idle_high: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_IDLE && $past(state) == SSFS_IDLE && $stable(idleClk)
         && cpol && !isHalf) |-> (sclk && fs && !out))
        else $error("Idle pins wrong with high clock polarity.");
    a_clock_pad: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_IDLE && !serialClockOe) |=> (state == SSFS_IDLE))
        else $error("Port with its clock pad off left idle.");
    a_frame_start: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_IDLE && doLoad) |=> (!fs && outOe))
        else $error("Frame did not start after a load.");
    a_phase0_lead: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_LEAD && !cpha) |=> (sclk == cpol) ##1 (sclk != cpol))
        else $error("Phase zero first edge misplaced.");
    a_phase1_lead: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_LEAD && cpha) |=> (sclk != cpol && out == $past(txShift[15])))
        else $error("Phase one launch edge misplaced.");
    a_select_release: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_BITS && half && bitCnt == lastIdx && !isHalf && !(cpha && avail))
        |=> !fs ##1 fs)
        else $error("Select not released one period after last capture.");
    a_phase0_gap: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_BITS && half && bitCnt == lastIdx && !isHalf && !cpha)
        |=> (state == SSFS_TAIL) ##1 fs)
        else $error("Phase zero word did not release select.");
    a_phase1_burst: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_BITS && half && bitCnt == lastIdx && !isHalf && cpha && avail
         && cfgEnable) |=> (!fs && state == SSFS_BITS && bitCnt == 4'h0))
        else $error("Select broke inside a phase one burst.");
    a_control_msb: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_IDLE && doLoad && isHalf) |=> (!fs && out == $past(txHold[7])))
        else $error("Control MSB not on the line at select fall.");
    a_wait_clock: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_WAIT && !half) |=> sclk ##1 (!sclk && state == SSFS_RESP))
        else $error("Wait state is not one serial clock.");
    a_single_push: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_TAIL) |=> (fs && rxTog != $past(rxTog)))
        else $error("Receive value not pushed at select rise.");
    a_half_chain: assert property (@(posedge linkClk) disable iff (!reset_n)
        (state == SSFS_RESP && half && bitCnt == cfgSize && avail && cfgEnable)
        |=> (!fs && !sclk && state == SSFS_BITS && rxTog != $past(rxTog)))
        else $error("Next control byte did not follow at once.");
    a_size_align: assert property (@(posedge linkClk) disable iff (!reset_n)
        (doLoad && !isHalf) |=> (txShift[15] == $past(txHold[cfgSize])))
        else $error("Word not loaded MSB first at its size.");

    c_phase1_burst: cover property (@(posedge linkClk) disable iff (!reset_n)
        state == SSFS_BITS && doLoad);
    c_half_single: cover property (@(posedge linkClk) disable iff (!reset_n)
        state == SSFS_TAIL && isHalf);
    c_half_chain: cover property (@(posedge linkClk) disable iff (!reset_n)
        state == SSFS_RESP && doLoad);
    c_phase0_word: cover property (@(posedge linkClk) disable iff (!reset_n)
        state == SSFS_TAIL && !isHalf && !cpha);
endmodule : ssfs_sequencer

/* File: bench/ssfs_peer.sv */
// Behavioural far-side slave: captures the master's words and answers with a fixed reply.
// Assumes the bench resolves the pins and keeps the settings stable while a frame runs.
`timescale 1ns/100ps
module ssfs_peer (
    input wire logic sclk,
    input wire logic selN,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic half,
    input wire logic [3:0] sizeCode,
    input wire logic [15:0] reply,
    output logic miso,
    output logic [15:0] capWord,
    output realtime capT
);
    int n;
    int outCnt = 0;
    int edges = 0;
    int k;
    logic [15:0] capSh = 16'h0000;

    // Bits per word, or per whole control, wait and reply frame in half-duplex.
    always_comb n = half ? 10 + sizeCode : 1 + sizeCode;

    // Outputs start at a known level before the first frame.
    initial begin
        miso = 1'h0;
        capWord = 16'h0000;
        capT = 0.0;
    end

    // A new frame restarts the counters; phase zero outside half-duplex shows its MSB at once.
    always @(negedge selN) begin
        edges = 0;
        outCnt = 0;
        if (!cpha && !half) begin
            miso <= reply[sizeCode];
            outCnt = 1;
        end
    end

    // A released line shows the inverse of its last value, never a held copy.
    always @(posedge selN) miso <= (miso === 1'h1) ? 1'h0 : 1'h1;

    // Pin engine, clocked by the master's own serial clock while selected.
    always @(posedge sclk or negedge sclk) begin
        if (selN === 1'h0) begin
            k = edges % n;
            if (half && sclk) begin
                // Control bits are latched on rising edges.
                if (k < 8) capSh = {capSh[14:0], mosi};
                if (k == 7) capWord <= capSh;
                capT = $realtime;
                edges++;
            end else if (half) begin
                // Reply bits go out on falling edges after the wait; else the line shows the inverse of its last value.
                miso <= (k >= 9) ? reply[sizeCode - (k - 9)] : ~miso;
            end else if (sclk == (cpol == cpha)) begin
                capSh = {capSh[14:0], mosi};
                capT = $realtime;
                edges++;
                if (edges % n == 0) capWord <= capSh;
            end else begin
                // Shift edge; phase one puts its first bit out here too.
                miso <= reply[sizeCode - outCnt % n];
                outCnt++;
            end
        end
    end
endmodule : ssfs_peer

/* File: bench/ssfs_sequencer_bench.sv */
// Self-checking bench for the frame sequencer with a behavioural slave on its pins.
// Assumes the design package, the design and ssfs_peer are compiled before it.
`timescale 1ns/100ps
module ssfs_sequencer_bench
    import ssfs_pkg::*;
();
    typedef struct packed {
        logic [1:0] fmt;
        logic cpol;
        logic cpha;
        logic [3:0] size;
        logic [15:0] tx;
        logic [15:0] reply;
    } ssfs_row_t;

    logic clk_sys = 1'h0;
    logic linkClk = 1'h0;
    logic reset_n = 1'h0;
    logic portEnable = 1'h0;
    logic masterMode = 1'h1;
    logic clockPolarityBit = 1'h0;
    logic clockPhaseBit = 1'h0;
    logic [1:0] frameFormat = FMT_SPI;
    logic [3:0] dataSizeCode = 4'h7;
    logic txValid = 1'h0;
    logic [15:0] txData = 16'h0000;
    logic [15:0] reply = 16'h0000;
    logic txReady, rxValid, busy, serialClockOut, serialClockOe, serialIn;
    logic frameSelectOut, frameSelectOe, serialOut, serialOutOe;
    logic [DATA_W-1:0] rxData;
    logic [15:0] capWord;
    realtime capT;
    realtime selRiseT = 0.0;
    int fail_count = 0;
    int checks = 0;
    int selRises = 0;
    int base;
    // Rows: format, polarity, phase, size code, word sent, slave reply.
    ssfs_row_t rows [6] = '{
        '{FMT_SPI, 1'h0, 1'h0, 4'h7, 16'h00A5, 16'h003C},
        '{FMT_SPI, 1'h0, 1'h1, 4'h3, 16'hFFF9, 16'h0006},
        '{FMT_SPI, 1'h1, 1'h0, 4'hF, 16'hC3A1, 16'h5E0F},
        '{FMT_SPI, 1'h1, 1'h1, 4'hB, 16'h0F35, 16'h0A5C},
        '{FMT_HALF, 1'h0, 1'h0, 4'h3, 16'h00C9, 16'h000D},
        '{FMT_HALF, 1'h0, 1'h0, 4'hF, 16'h7F1E, 16'hB42D}};

    // The link clock is offset so its edges drift against the system clock.
    always #50 clk_sys = ~clk_sys;
    initial begin
        #37;
        forever #80 linkClk = ~linkClk;
    end

    ssfs_sequencer ssfs_sequencer_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .linkClk(linkClk),
        .portEnable(portEnable), .masterMode(masterMode),
        .clockPolarityBit(clockPolarityBit), .clockPhaseBit(clockPhaseBit),
        .frameFormat(frameFormat), .dataSizeCode(dataSizeCode),
        .txValid(txValid), .txReady(txReady), .txData(txData),
        .rxValid(rxValid), .rxData(rxData), .busy(busy),
        .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
        .frameSelectOut(frameSelectOut), .frameSelectOe(frameSelectOe),
        .serialOut(serialOut), .serialOutOe(serialOutOe), .serialIn(serialIn)
    );

    // An unselected or unpowered select pad reads as deselected.
    ssfs_peer ssfs_peer_i (.sclk(serialClockOut), .selN(frameSelectOut | ~frameSelectOe),
        .mosi(serialOut), .cpol(clockPolarityBit), .cpha(clockPhaseBit),
        .half(frameFormat == FMT_HALF), .sizeCode(dataSizeCode), .reply(reply),
        .miso(serialIn), .capWord(capWord), .capT(capT));

    // Every select release is counted and timed.
    always @(posedge frameSelectOut) begin
        selRises++;
        selRiseT = $realtime;
    end

    task automatic chk16(input string what, input logic [15:0] expv, input logic [15:0] got);
        checks++;
        if (got !== expv) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
        end
    endtask : chk16

    task automatic chk1(input string what, input logic expv, input logic got);
        checks++;
        if (got !== expv) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", what, expv, got);
        end
    endtask : chk1

    task automatic results;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    // Settings change only while the port is off, as the design requires.
    task automatic setup(input ssfs_row_t r, input logic master);
        @(posedge clk_sys) portEnable <= 1'h0;
        repeat (4) @(posedge clk_sys);
        frameFormat <= r.fmt;
        clockPolarityBit <= r.cpol;
        clockPhaseBit <= r.cpha;
        dataSizeCode <= r.size;
        masterMode <= master;
        reply <= r.reply;
        repeat (8) @(posedge clk_sys);
        portEnable <= 1'h1;
        repeat (8) @(posedge clk_sys);
    endtask : setup

    // Offer one word and hold it until the edge that takes it.
    task automatic send(input logic [15:0] word);
        @(negedge clk_sys);
        for (int i = 0; i < 300 && txReady !== 1'h1; i++) @(negedge clk_sys);
        @(posedge clk_sys) txValid <= 1'h1;
        txData <= word;
        @(posedge clk_sys) txValid <= 1'h0;
    endtask : send

    task automatic waitRx;
        @(negedge clk_sys);
        for (int i = 0; i < 600 && rxValid !== 1'h1; i++) @(negedge clk_sys);
    endtask : waitRx

    task automatic doRow(input ssfs_row_t r);
        logic [15:0] mask;
        logic [15:0] cmask;
        mask = 16'hFFFF >> (4'hF - r.size);
        cmask = (r.fmt == FMT_HALF) ? 16'h00FF : mask;
        setup(r, 1'h1);
        send(r.tx);
        for (int i = 0; i < 40 && frameSelectOut !== 1'h0; i++) @(negedge clk_sys);
        @(negedge clk_sys);
        chk1("tx pad", 1'h1, serialOutOe);
        // Busy crosses two flip-flops, so it is looked at a few cycles into the word.
        repeat (3) @(negedge clk_sys);
        chk1("busy", 1'h1, busy);
        waitRx();
        chk1("rx valid", 1'h1, rxValid);
        chk1("busy end", 1'h0, busy);
        chk16("rxData", r.reply & mask, rxData);
        chk16("peer word", r.tx & cmask, capWord & cmask);
        chk16("select lag", 16'h0140, 16'(int'(selRiseT - capT)));
        chk1("idle clock", (r.fmt == FMT_HALF) ? 1'h0 : r.cpol, serialClockOut);
        chk1("idle select", 1'h1, frameSelectOut);
        chk1("idle data", 1'h0, serialOut);
        chk1("clock pad", 1'h1, serialClockOe);
    endtask : doRow

    // Two words back to back; the select release count tells the framing apart.
    task automatic burst(input ssfs_row_t r, input logic [15:0] rises);
        logic [15:0] cmask;
        cmask = (r.fmt == FMT_HALF) ? 16'h00FF : 16'hFFFF >> (4'hF - r.size);
        setup(r, 1'h1);
        base = selRises;
        send(r.tx);
        send(~r.tx);
        waitRx();
        waitRx();
        chk16("burst rx", r.reply & (16'hFFFF >> (4'hF - r.size)), rxData);
        chk16("burst word", ~r.tx & cmask, capWord & cmask);
        chk16("select releases", rises, 16'(selRises - base));
    endtask : burst

    initial begin
        repeat (16) @(posedge clk_sys);
        chk1("reset ready", 1'h1, txReady);
        chk16("reset rxData", WORD_ZERO, rxData);
        chk1("reset select", RESET_SELECT, frameSelectOut);
        chk1("reset clock", 1'h0, serialClockOut);
        chk1("reset quiet", 1'h0, serialClockOe | frameSelectOe | serialOutOe | busy);
        reset_n <= 1'h1;
        foreach (rows[k]) doRow(rows[k]);
        burst(rows[0], 16'h0002);
        burst(rows[2], 16'h0002);
        burst(rows[3], 16'h0001);
        burst(rows[5], 16'h0001);
        // A slave-configured port keeps its pads off and never frames.
        // No far master drives select here, so its setup and hold are met trivially.
        setup(rows[1], 1'h0);
        base = selRises;
        send(16'h0009);
        repeat (60) @(negedge clk_sys);
        chk1("slave pads", 1'h0, serialClockOe | frameSelectOe);
        chk16("slave frames", 16'h0000, 16'(selRises - base));
        chk1("slave held", 1'h0, txReady);
        results();
    end

    // A hang is cut short well beyond the expected run length.
    initial begin
        #1_000_000;
        fail_count++;
        results();
    end
endmodule : ssfs_sequencer_bench
